/* File: epwm_bridge_model.sv */
// epwm_bridge_model: switch drivers at the four pins, pull-downs at pins b c d.
// assumes one sensor that drives pin a only while the unit does not.
`timescale 1ns/100ps

module epwm_bridge_model (
   // from the unit
   input wire epwm_pkg::epwm_pins_t pins_i,
   // sensor level for pin a
   input wire logic sense_i,
   // wire levels back to the unit
   output logic [3:0] pin_o
);
   // pull-downs keep switches off while a pin floats
   assign pin_o[3:1] = pins_i.oe[3:1] & pins_i.o[3:1];
   // sensor only wins when the unit releases pin a
   assign pin_o[0] = pins_i.oe[0] ? pins_i.o[0] : sense_i;
endmodule : epwm_bridge_model

/* File: epwm_pkg.sv */
// epwm_pkg: constants and types for the enhanced pwm steering block.
// assumes a 32-bit classic wishbone slave with 8-bit registers per word.
package epwm_pkg;

   // ****************************************
   // register word offsets (byte addresses)
   // ****************************************
   localparam logic [5:0] OFS_CONTROL = 6'h00; // unit_control_register
   localparam logic [5:0] OFS_STEER = 6'h04; // steering_register
   localparam logic [5:0] OFS_DUTY_HI = 6'h08; // duty_high_register
   localparam logic [5:0] OFS_PERIOD = 6'h0c; // period timer limit
   localparam logic [5:0] OFS_CMP_LO = 6'h10; // compare/capture low byte
   localparam logic [5:0] OFS_CMP_HI = 6'h14; // compare/capture high byte
   localparam logic [5:0] OFS_FLAGS = 6'h18; // interrupt_flag_register
   localparam logic [5:0] OFS_PORT_DAT = 6'h1c; // port latch
   localparam logic [5:0] OFS_PORT_OE = 6'h20; // pin output drivers

   // ****************************************
   // reset values
   // ****************************************
   localparam logic [7:0] RST_CONTROL = 8'h00;
   localparam logic [4:0] RST_STEER = 5'h01; // only out_a steered
   localparam logic [7:0] RST_PERIOD = 8'hff;
   localparam logic [3:0] RST_PORT_OE = 4'h0; // all pins high impedance

   // ****************************************
   // mode encodings of unit_mode_select
   // ****************************************
   localparam logic [3:0] MODE_OFF = 4'h0;
   localparam logic [3:0] MODE_CMP_TOGGLE = 4'h2;
   localparam logic [3:0] MODE_CAP_FALL = 4'h4;
   localparam logic [3:0] MODE_CAP_RISE = 4'h5;
   localparam logic [3:0] MODE_CAP_RISE4 = 4'h6;
   localparam logic [3:0] MODE_CAP_RISE16 = 4'h7;
   localparam logic [3:0] MODE_CMP_SET = 4'h8;
   localparam logic [3:0] MODE_CMP_CLR = 4'h9;
   localparam logic [3:0] MODE_CMP_SOFT = 4'ha;
   localparam logic [3:0] MODE_CMP_SPECIAL = 4'hb;
   localparam logic [1:0] MODE_HI_PWM = 2'h3;

   // output_config encodings
   localparam logic [1:0] CFG_SINGLE = 2'h0;
   localparam logic [1:0] CFG_FULL_FWD = 2'h1;
   localparam logic [1:0] CFG_HALF = 2'h2;
   localparam logic [1:0] CFG_FULL_REV = 2'h3;

   // capture prescale terminal counts
   localparam logic [3:0] CAP_DIV4_LAST = 4'h3;
   localparam logic [3:0] CAP_DIV16_LAST = 4'hf;
   localparam logic [1:0] SUB_LAST = 2'h3; // last quarter step of a count

   // pin bundle toward the four outputs
   typedef struct packed {
      logic [3:0] o;  // driven level, d c b a
      logic [3:0] oe; // driver enable, high while driving
   } epwm_pins_t;

endpackage : epwm_pkg

/* File: epwm_steer.sv */
// epwm_steer: enhanced capture/compare/pwm unit with output steering.
// assumes a synchronous wishbone master, synchronous pin inputs, 100 MHz.
//
// How it works
// - steer sync clear: enables apply after write
// - steer sync set: enables apply at period start
// - period flag set when each period begins
// - after reset all four pins high impedance
// - non-pwm modes: a is ccp pin, bcd port
// - config 00: only a modulated unless steered
// - config 01: d modulated, a active, b c inactive
// - config 10: a and b modulated as pair
// - config 11: b modulated, c active, a d inactive
// - duty is high byte plus two low bits
// - mode 0000 turns unit off and idles it
// - capture on falling, rising, 4th, 16th edge
// - mode 0010 toggles compare pin on match
// - 1000 init low set; 1001 init high clear
// - mode 1010 flags only, pin back to port
// - mode 1011 resets timer, second unit starts adc
// - mode bits 1 and 0 set pair polarity
// - plain units treat 11xx as pwm only
// - steering routes polarised pwm onto enabled pins
// - cleared steering enable returns pin to port
//
// Design decisions made here: the register offsets and the Wishbone slave port.
`timescale 1ns/100ps

module epwm_steer #(
   parameter bit ENHANCED = 1'b1,   // clear for a plain unit
   parameter bit SECOND_UNIT = 1'b0 // set on the unit that starts the adc
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [5:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // pins d c b a
   input wire logic [3:0] pin_i,
   output epwm_pkg::epwm_pins_t pins_o,
   // system side
   input wire logic adc_enable_i,
   output logic adc_start_o,
   output logic period_flag_o,
   output logic event_flag_o
);

   // ****************************************
   // registers
   // ****************************************
   logic [7:0] control_r;     // config, duty low bits, mode
   logic [4:0] steer_r;       // sync bit and written enables
   logic [3:0] steer_live_r;  // enables in force at the pins
   logic steer_pend_r;        // synchronised update waiting
   logic [7:0] duty_hi_r;
   logic [7:0] period_r;
   logic [15:0] cmp_r;        // compare value or captured time
   logic [3:0] port_dat_r;
   logic [3:0] port_oe_r;
   logic period_flag_r;
   logic event_flag_r;
   logic [7:0] tmr_r;         // pwm period timer
   logic [1:0] sub_r;         // quarter steps for the duty low bits
   logic [15:0] timer_one_r;       // capture/compare time base
   logic cmp_out_r;           // compare pin level
   logic cap_prev_r;          // last sample of out_a input
   logic [3:0] cap_cnt_r;     // capture prescale count
   logic adc_start_r;
   logic ack_r;
   logic [31:0] dat_r;

   // ****************************************
   // field decode
   // ****************************************
   wire [3:0] mode = control_r[3:0];
   wire [1:0] cfg = control_r[7:6];
   wire [1:0] duty_lo = control_r[5:4];
   wire pwm_mode = (mode[3:2] == epwm_pkg::MODE_HI_PWM);
   wire unit_off = (mode == epwm_pkg::MODE_OFF);
   // plain unit ignores the config field and runs single output
   wire [1:0] cfg_eff = ENHANCED ? cfg : epwm_pkg::CFG_SINGLE;
   // plain unit has no polarity control
   wire [1:0] pol = ENHANCED ? mode[1:0] : 2'h0;

   // ****************************************
   // bus decode
   // ****************************************
   wire bus_req = wb_cyc_i & wb_stb_i;
   // write takes effect at the edge where ack is seen high
   wire wr_go = bus_req & wb_we_i & ack_r & wb_sel_i[0];
   wire wr_control = wr_go & (wb_adr_i == epwm_pkg::OFS_CONTROL);
   wire wr_steer = wr_go & (wb_adr_i == epwm_pkg::OFS_STEER);
   wire wr_duty_hi = wr_go & (wb_adr_i == epwm_pkg::OFS_DUTY_HI);
   wire wr_period = wr_go & (wb_adr_i == epwm_pkg::OFS_PERIOD);
   wire wr_cmp_lo = wr_go & (wb_adr_i == epwm_pkg::OFS_CMP_LO);
   wire wr_cmp_hi = wr_go & (wb_adr_i == epwm_pkg::OFS_CMP_HI);
   wire wr_flags = wr_go & (wb_adr_i == epwm_pkg::OFS_FLAGS);
   wire wr_pdat = wr_go & (wb_adr_i == epwm_pkg::OFS_PORT_DAT);
   wire wr_poe = wr_go & (wb_adr_i == epwm_pkg::OFS_PORT_OE);
   wire [7:0] wdat = wb_dat_i[7:0];

   // read mux, if/else chain; unmapped reads zero
   logic [7:0] rd_val;
   always_comb begin
      if (wb_adr_i == epwm_pkg::OFS_CONTROL) begin
         rd_val = control_r;
      end else if (wb_adr_i == epwm_pkg::OFS_STEER) begin
         rd_val = {3'h0, steer_r};
      end else if (wb_adr_i == epwm_pkg::OFS_DUTY_HI) begin
         rd_val = duty_hi_r;
      end else if (wb_adr_i == epwm_pkg::OFS_PERIOD) begin
         rd_val = period_r;
      end else if (wb_adr_i == epwm_pkg::OFS_CMP_LO) begin
         rd_val = cmp_r[7:0];
      end else if (wb_adr_i == epwm_pkg::OFS_CMP_HI) begin
         rd_val = cmp_r[15:8];
      end else if (wb_adr_i == epwm_pkg::OFS_FLAGS) begin
         rd_val = {6'h00, event_flag_r, period_flag_r};
      end else if (wb_adr_i == epwm_pkg::OFS_PORT_DAT) begin
         rd_val = {4'h0, port_dat_r};
      end else if (wb_adr_i == epwm_pkg::OFS_PORT_OE) begin
         rd_val = {4'h0, port_oe_r};
      end else begin
         rd_val = 8'h00;
      end
   end

   // ****************************************
   // pwm timing
   // ****************************************
   // 10-bit duty against timer plus quarter step
   wire [9:0] duty = {duty_hi_r, duty_lo};
   wire [9:0] pos = {tmr_r, sub_r};
   wire pwm_raw = (pos < duty);
   wire period_end = pwm_mode & (tmr_r == period_r) &
                     (sub_r == epwm_pkg::SUB_LAST);

   // compare match on the 16-bit time base
   wire cmp_match = (timer_one_r == cmp_r);
   wire is_cmp = (mode == epwm_pkg::MODE_CMP_TOGGLE) |
                 (mode[3:2] == 2'h2);

   // capture edge detect and prescale
   wire rise = pin_i[0] & ~cap_prev_r;
   wire fall = ~pin_i[0] & cap_prev_r;
   wire cap_last4 = (cap_cnt_r == epwm_pkg::CAP_DIV4_LAST);
   wire cap_last16 = (cap_cnt_r == epwm_pkg::CAP_DIV16_LAST);
   logic cap_evt;
   always_comb begin
      case (mode)
         epwm_pkg::MODE_CAP_FALL: cap_evt = fall;
         epwm_pkg::MODE_CAP_RISE: cap_evt = rise;
         epwm_pkg::MODE_CAP_RISE4: cap_evt = rise & cap_last4;
         epwm_pkg::MODE_CAP_RISE16: cap_evt = rise & cap_last16;
         default: cap_evt = 1'b0;
      endcase
   end
   wire cap_mode = (mode[3:2] == 2'h1);

   // compare events that raise the unit flag
   wire cmp_flag_evt = cmp_match & (mode[3:2] == 2'h2);
   wire special_evt = cmp_match &
                      (mode == epwm_pkg::MODE_CMP_SPECIAL);
   wire unit_evt = cap_evt | cmp_flag_evt;

   // ****************************************
   // output steering and configuration
   // ****************************************
   // unit_val: level the unit wants, unit_sel: pin owned by the unit
   logic [3:0] unit_val;
   logic [3:0] unit_sel;
   always_comb begin
      unit_val = 4'h0;
      unit_sel = 4'h0;
      if (pwm_mode) begin
         case (cfg_eff)
            epwm_pkg::CFG_SINGLE: begin
               // steered pins carry the same wave
               unit_sel = steer_live_r;
               unit_val = {4{pwm_raw}};
            end
            epwm_pkg::CFG_FULL_FWD: begin
               unit_sel = 4'hf;
               unit_val = {pwm_raw, 1'b0, 1'b0, 1'b1};
            end
            epwm_pkg::CFG_HALF: begin
               // complementary pair, no dead band here
               unit_sel = 4'h3;
               unit_val = {1'b0, 1'b0, ~pwm_raw, pwm_raw};
            end
            default: begin
               unit_sel = 4'hf;
               unit_val = {1'b0, 1'b1, pwm_raw, 1'b0};
            end
         endcase
         // active-low pairs: bit 1 for a/c, bit 0 for b/d
         unit_val = unit_val ^ {pol[0], pol[1], pol[0], pol[1]};
      end else if (is_cmp) begin
         // only out_a serves as the compare pin
         unit_sel = {3'h0, (mode != epwm_pkg::MODE_CMP_SOFT) &
                    (mode != epwm_pkg::MODE_CMP_SPECIAL)};
         unit_val = {3'h0, cmp_out_r};
      end
   end

   // pin drivers follow the port enables, which reset off
   assign pins_o.o = (unit_sel & unit_val) | (~unit_sel & port_dat_r);
   assign pins_o.oe = port_oe_r;

   // ****************************************
   // bus and register process
   // ****************************************
   // ack one cycle after request, dropped the cycle after
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_r <= 1'b0;
         dat_r <= 32'h0000_0000;
      end else begin
         ack_r <= bus_req & ~ack_r;
         if (bus_req & ~ack_r) begin
            dat_r <= {24'h00_0000, rd_val};
         end
      end
   end
   assign wb_ack_o = ack_r;
   assign wb_dat_o = dat_r;

   // plain configuration registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         control_r <= epwm_pkg::RST_CONTROL;
         duty_hi_r <= 8'h00;
         period_r <= epwm_pkg::RST_PERIOD;
         port_dat_r <= 4'h0;
         port_oe_r <= epwm_pkg::RST_PORT_OE;
      end else begin
         if (wr_control) control_r <= wdat;
         if (wr_duty_hi) duty_hi_r <= wdat;
         if (wr_period) period_r <= wdat;
         if (wr_pdat) port_dat_r <= wdat[3:0];
         if (wr_poe) port_oe_r <= wdat[3:0];
      end
   end

   // steering: immediate or deferred to the period start
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         steer_r <= epwm_pkg::RST_STEER;
         steer_live_r <= epwm_pkg::RST_STEER[3:0];
         steer_pend_r <= 1'b0;
      end else begin
         if (wr_steer) begin
            steer_r <= wdat[4:0];
         end
         if (wr_steer & ~wdat[4]) begin
            // may cut a pulse short, by design
            steer_live_r <= wdat[3:0];
            steer_pend_r <= 1'b0;
         end else if (wr_steer) begin
            steer_pend_r <= 1'b1;
         end else if (steer_pend_r & (period_end | ~pwm_mode)) begin
            // latest written value, so older writes are lost
            steer_live_r <= steer_r[3:0];
            steer_pend_r <= 1'b0;
         end
      end
   end

   // pwm period timer; frozen and cleared outside pwm
   always_ff @(posedge clk_i) begin
      if (rst_i | ~pwm_mode) begin
         tmr_r <= 8'h00;
         sub_r <= 2'h0;
      end else if (period_end) begin
         tmr_r <= 8'h00;
         sub_r <= 2'h0;
      end else begin
         sub_r <= sub_r + 2'h1;
         if (sub_r == epwm_pkg::SUB_LAST) tmr_r <= tmr_r + 8'h01;
      end
   end

   // capture/compare time base and compare pin
   always_ff @(posedge clk_i) begin
      // a control write while off must still load the initial pin level
      if (rst_i | (unit_off & ~wr_control)) begin
         timer_one_r <= 16'h0000;
         cmp_out_r <= 1'b0;
         cap_cnt_r <= 4'h0;
         cap_prev_r <= 1'b0;
         adc_start_r <= 1'b0;
      end else begin
         cap_prev_r <= pin_i[0];
         adc_start_r <= special_evt & SECOND_UNIT & adc_enable_i;
         if (special_evt) begin
            timer_one_r <= 16'h0000;
         end else begin
            timer_one_r <= timer_one_r + 16'h0001;
         end
         if (wr_control & (wdat[3:0] == epwm_pkg::MODE_CMP_SET)) begin
            cmp_out_r <= 1'b0;
         end else if (wr_control & (wdat[3:0] == epwm_pkg::MODE_CMP_CLR)) begin
            cmp_out_r <= 1'b1;
         end else if (cmp_match) begin
            case (mode)
               epwm_pkg::MODE_CMP_TOGGLE: cmp_out_r <= ~cmp_out_r;
               epwm_pkg::MODE_CMP_SET: cmp_out_r <= 1'b1;
               epwm_pkg::MODE_CMP_CLR: cmp_out_r <= 1'b0;
               default: cmp_out_r <= cmp_out_r;
            endcase
         end
         // prescale counts rising edges only
         if (wr_control | ~cap_mode) begin
            cap_cnt_r <= 4'h0;
         end else if (rise & (cap_evt | (mode == epwm_pkg::MODE_CAP_RISE4) &
                      cap_last4)) begin
            cap_cnt_r <= 4'h0;
         end else if (rise) begin
            cap_cnt_r <= cap_cnt_r + 4'h1;
         end
      end
   end
   assign adc_start_o = adc_start_r;

   // compare value, overwritten by captures
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cmp_r <= 16'h0000;
      end else if (cap_mode & cap_evt) begin
         cmp_r <= timer_one_r;
      end else begin
         if (wr_cmp_lo) cmp_r[7:0] <= wdat;
         if (wr_cmp_hi) cmp_r[15:8] <= wdat;
      end
   end

   // sticky flags, write one to clear, set beats clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         period_flag_r <= 1'b0;
         event_flag_r <= 1'b0;
      end else begin
         if (period_end) begin
            period_flag_r <= 1'b1;
         end else if (wr_flags & wdat[0]) begin
            period_flag_r <= 1'b0;
         end
         if (unit_evt & ~unit_off) begin
            event_flag_r <= 1'b1;
         end else if (wr_flags & wdat[1]) begin
            event_flag_r <= 1'b0;
         end
      end
   end
   assign period_flag_o = period_flag_r;
   assign event_flag_o = event_flag_r;

endmodule : epwm_steer

/* File: epwm_steer_chk.sv */
// epwm_steer_chk: port-level assertions for epwm_steer.
// assumes the bind below; mirrors only control and port latch writes.
`timescale 1ns/100ps

module epwm_steer_chk (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // bus
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [5:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic wb_ack_o,
   // pins and flags
   input wire epwm_pkg::epwm_pins_t pins_o,
   input wire logic event_flag_o
);
   // ***************
   // mirrors
   // ***************
   logic wr; // write taken this edge
   logic oe_wr; // driver enable write
   logic pwm; // unit in pwm mode
   logic [7:0] ctl_r; // control copy
   logic [3:0] lat_r; // port latch copy
   assign wr = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & wb_sel_i[0];
   assign oe_wr = wr & (wb_adr_i == epwm_pkg::OFS_PORT_OE);
   assign pwm = (ctl_r[3:2] == epwm_pkg::MODE_HI_PWM);
   // copies update on the same edge as the unit's registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctl_r <= 8'h00;
         lat_r <= 4'h0;
      end else if (wr && wb_adr_i == epwm_pkg::OFS_CONTROL) begin
         ctl_r <= wb_dat_i[7:0];
      end else if (wr && wb_adr_i == epwm_pkg::OFS_PORT_DAT) begin
         lat_r <= wb_dat_i[3:0];
      end
   end

   // ***************
   // assertions
   // ***************
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_oe_reset_off: assert property (
      $fell(rst_i) |-> pins_o.oe == 4'h0)
      else $error("drivers on after reset");
   a_oe_by_write: assert property (
      $changed(pins_o.oe) && !$past(rst_i) |-> $past(oe_wr))
      else $error("drivers changed without a write");
   a_port_nonpwm: assert property (
      !pwm |-> pins_o.o[3:1] == lat_r[3:1])
      else $error("b c d not port pins outside pwm");
   a_a_to_port: assert property (
      ctl_r[3:0] inside {4'h0, 4'ha, 4'hb} |-> pins_o.o[0] == lat_r[0])
      else $error("pin a not returned to port");
   a_full_fwd: assert property (
      pwm && ctl_r[7:6] == 2'h1 |->
         pins_o.o[2:0] == {ctl_r[1], ctl_r[0], ~ctl_r[1]})
      else $error("forward bridge levels wrong");
   a_full_rev: assert property (
      pwm && ctl_r[7:6] == 2'h3 |->
         {pins_o.o[3:2], pins_o.o[0]} == {ctl_r[0], ~ctl_r[1], ctl_r[1]})
      else $error("reverse bridge levels wrong");
   a_half_pair: assert property (
      pwm && ctl_r[7:6] == 2'h2 |->
         pins_o.o[1] == (~(pins_o.o[0] ^ ctl_r[1]) ^ ctl_r[0])
         && pins_o.o[3:2] == lat_r[3:2])
      else $error("half bridge pair wrong");
   a_cmp_init: assert property (
      wr && wb_adr_i == epwm_pkg::OFS_CONTROL && wb_dat_i[3:1] == 3'h4
      |=> pins_o.o[0] == $past(wb_dat_i[0]))
      else $error("compare pin not initialised");

   // main scenarios reached
   c_half: cover property (pwm && ctl_r[7:6] == 2'h2);
   c_event: cover property ($rose(event_flag_o));
   c_oe_on: cover property (pins_o.oe == 4'hf);
endmodule : epwm_steer_chk

bind epwm_steer epwm_steer_chk u_chk (
   .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
   .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .pins_o(pins_o),
   .event_flag_o(event_flag_o)
);

/* File: epwm_steer_tb_top.sv */
// epwm_steer_tb_top: self-checking bench for epwm_steer.
// assumes the checker bind and the bridge model; 100 MHz clock.
`timescale 1ns/100ps

module epwm_steer_tb_top;
   // ***************
   // signals
   // ***************
   localparam logic [7:0] PER = 8'h03; // short period limit
   localparam int PLEN = (PER + 1) * 4; // clocks per period
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0;
   logic we = 1'b0;
   logic [5:0] adr = 6'h00;
   logic [3:0] sel = 4'h1;
   logic [31:0] wdat = 32'h0;
   logic sense = 1'b0; // capture sensor
   logic adc_en = 1'b1;
   logic [31:0] rdat;
   logic ack;
   logic adc_st;
   logic pflag;
   logic eflag;
   logic [3:0] pin_lv;
   epwm_pkg::epwm_pins_t pins;
   int err_count = 0;
   int checks = 0;

   always #5 clk_i = ~clk_i;

   epwm_steer #(.ENHANCED(1'b1), .SECOND_UNIT(1'b1)) u_dut (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .pin_i(pin_lv), .pins_o(pins),
      .adc_enable_i(adc_en), .adc_start_o(adc_st),
      .period_flag_o(pflag), .event_flag_o(eflag));
   epwm_bridge_model u_bridge (.pins_i(pins), .sense_i(sense),
      .pin_o(pin_lv));

   // ***************
   // tasks
   // ***************
   task automatic end_sim;
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : end_sim

   task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
      checks++;
      if (g !== e) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic hang(string nm);
      err_count++;
      $display("CHECK FAILED %s expected done seen timeout", nm);
      end_sim();
   endtask : hang

   // one classic cycle; request held until ack is sampled
   task automatic wb(logic w, logic [5:0] a, logic [7:0] d,
                     output logic [7:0] q);
      int n;
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= {24'h0, d};
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 20);
      if (ack !== 1'b1) hang("bus ack");
      q = rdat[7:0];
      cyc <= 1'b0;
      we <= 1'b0;
      @(posedge clk_i); // idle cycle between requests
   endtask : wb

   task automatic wr(logic [5:0] a, logic [7:0] d);
      logic [7:0] q;
      wb(1'b1, a, d, q);
   endtask : wr

   task automatic rd(string nm, logic [5:0] a, logic [7:0] e);
      logic [7:0] q;
      wb(1'b0, a, 8'h00, q);
      chk(nm, e, q);
   endtask : rd

   // clear the sticky flag, then wait for the next period start
   task automatic wait_period;
      int n;
      wr(6'h18, 8'h01);
      n = 0;
      while (pflag !== 1'b1 && n < 4 * PLEN) begin
         @(posedge clk_i);
         n++;
      end
      if (pflag !== 1'b1) hang("period flag");
   endtask : wait_period

   task automatic pulse;
      sense <= 1'b1;
      repeat (2) @(posedge clk_i);
      sense <= 1'b0;
      repeat (2) @(posedge clk_i);
   endtask : pulse

   // high cycles per pin over one period
   task automatic count_hi(output int c [4]);
      c = '{0, 0, 0, 0};
      repeat (PLEN) begin
         @(posedge clk_i);
         for (int k = 0; k < 4; k++) c[k] += (pins.o[k] === 1'b1);
      end
   endtask : count_hi

   // duty clamps at a full period; inverted pins count the rest
   function automatic logic [7:0] exp_cnt(int duty, bit inv);
      int h;
      h = (duty > PLEN) ? PLEN : duty;
      return 8'(inv ? PLEN - h : h);
   endfunction : exp_cnt

   // ***************
   // main sequence
   // ***************
   initial begin
      logic [5:0] radr [9] = '{6'h00, 6'h04, 6'h08, 6'h0c, 6'h10,
                               6'h14, 6'h18, 6'h20, 6'h24};
      logic [7:0] rval [9] = '{8'h00, 8'h01, 8'h00, 8'hff, 8'h00,
                               8'h00, 8'h00, 8'h00, 8'h00};
      int capn [4] = '{1, 1, 4, 16}; // edges per capture
      logic [7:0] cmode [5] = '{8'h02, 8'h08, 8'h09, 8'h0a, 8'h0b};
      logic cpin [5] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
      int mpin [4] = '{0, 3, 0, 1}; // modulated pin per config
      int c [4];
      int dh;
      int dl;
      int p;
      logic ini;
      logic adc;
      int n;
      void'($urandom(1));
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      // reset values, unmapped word ignored
      wr(6'h24, 8'h5a);
      foreach (radr[i]) rd("reset value", radr[i], rval[i]);
      chk("reset drivers", 8'h00, {4'h0, pins.oe});
      wr(6'h04, 8'hff);
      rd("steer bits", 6'h04, 8'h1f);
      $display("test registers done");
      // capture prescales, sensor on released pin a
      wr(6'h1c, 8'h0a);
      for (int i = 0; i < 4; i++) begin
         wr(6'h00, 8'h00);
         wr(6'h18, 8'h03);
         wr(6'h00, 8'(8'h04 + i));
         repeat (capn[i] - 1) pulse();
         repeat (4) @(posedge clk_i);
         chk("early capture", 8'h00, {7'h0, eflag});
         pulse();
         repeat (4) @(posedge clk_i);
         chk("capture flag", 8'h01, {7'h0, eflag});
      end
      $display("test capture done");
      // compare modes, match at 0x40 after a unit reset
      wr(6'h14, 8'h00);
      wr(6'h10, 8'h40);
      foreach (cmode[i]) begin
         wr(6'h00, 8'h00);
         wr(6'h18, 8'h03);
         wr(6'h00, cmode[i]);
         ini = pins.o[0];
         adc = 1'b0;
         n = 0;
         while (n < 100 && (cmode[i] == 8'h02 ? pins.o[0] === ini
                            : eflag !== 1'b1)) begin
            @(posedge clk_i);
            n++;
            adc |= (adc_st === 1'b1);
         end
         if (n >= 100) hang("compare match");
         @(posedge clk_i);
         adc |= (adc_st === 1'b1);
         chk("compare pin", {7'h0, (i == 0) ? ~ini : cpin[i]},
             {7'h0, pins.o[0]});
         if (i > 0) chk("compare flag", 8'h01, {7'h0, eflag});
         chk("adc start", {7'h0, i == 4}, {7'h0, adc});
      end
      $display("test compare done");
      // pwm: polarity first, one full cycle, then drivers
      wr(6'h00, 8'h0c);
      wr(6'h0c, PER);
      wr(6'h04, 8'h0f);
      for (int cf = 0; cf < 4; cf++) begin
         for (int md = 12; md < 16; md++) begin
            dh = $urandom_range(4, 0);
            dl = $urandom_range(3, 0);
            wr(6'h20, 8'h00); // drivers off before polarity
            wr(6'h08, 8'(dh));
            wr(6'h00, {cf[1:0], dl[1:0], md[3:0]});
            wait_period();
            wait_period();
            wr(6'h20, 8'h0f);
            count_hi(c);
            p = mpin[cf];
            chk("duty count", exp_cnt(dh * 4 + dl, p[0] ? md[0] : md[1]),
                8'(c[p]));
         end
      end
      $display("test pwm configs done");
      // steering: immediate release, then a deferred update
      wr(6'h00, 8'h0c);
      wr(6'h08, 8'h02);
      wait_period();
      wr(6'h04, 8'h00);
      chk("released pins", 8'h0a, {4'h0, pins.o});
      wait_period();
      wr(6'h04, 8'h1f);
      wr(6'h04, 8'h13);
      chk("pending steer", 8'h0a, {4'h0, pins.o});
      wait_period();
      count_hi(c);
      chk("steer a", 8'h08, 8'(c[0]));
      chk("steer b", 8'h08, 8'(c[1]));
      chk("steer c", 8'h00, 8'(c[2]));
      chk("steer d", 8'h10, 8'(c[3]));
      wr(6'h00, 8'h00);
      chk("off pins", 8'h0a, {4'h0, pins.o});
      wr(6'h18, 8'h03);
      rd("flags cleared", 6'h18, 8'h00);
      $display("test steering done");
      end_sim();
   end
endmodule : epwm_steer_tb_top
